// File: logic/dlgd_regs.sv
// Purpose: loop gain and damping configuration registers
// Assumes: Avalon-MM slave, 32-bit data, byte addresses
// Notes:   loop status inputs come from same-clock loop logic
//
// What this block does
// - damping codes 1..5 map to factor per bandwidth; 0, 6, 7 unused.
// - damping register resets to 0x13, code three, factor five.
// - damping bits 6:4 give main-loop gain for analog lock at or below 8kHz.
// - aux bits 6:4 give analog gain above 8kHz, unused when auto disabled.
// - aux bits 2:0 always give gain in digital feedback mode.
// - aux gain register is read/write, resets to 0xC2.
`include "dlgd_defines.svh"
module dlgd_regs
  import dlgd_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // avalon-mm slave
  input  wire logic [`DLGD_ADDR_W-1:0] address,
  input  wire logic                    read,
  input  wire logic                    write,
  input  wire logic [31:0]             writedata,
  input  wire logic [3:0]              byteenable,
  output logic [31:0]                  readdata,
  output logic                         waitrequest,
  // main loop status and config outputs
  input  wire dlgd_bw_e                main_bandwidth,
  input  wire logic                    main_analog_lowrate,
  output dlgd_damp_t                   main_damping_factor,
  output dlgd_gain_t                   main_lowrate_analog_gain,
  output logic                         main_gain_valid,
  // aux loop status and config outputs
  input  wire logic                    aux_analog_mode,
  input  wire logic                    aux_digital_mode,
  output dlgd_gain_t                   aux_detector_gain,
  output logic                         aux_gain_valid
);
  logic [7:0]  main_dpll_damping;
  logic [7:0]  second_dpll_detector_gain;
  logic        ack;
  logic        hit_main;
  logic        hit_aux;
  logic        wr_en;
  logic [31:0] next_readdata;
  logic [2:0]  main_damping_select;
  logic [2:0]  main_lowrate_gain_field;
  logic        aux_auto_gain_enable;
  logic [2:0]  aux_analog_feedback_gain;
  logic [2:0]  aux_digital_feedback_gain;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // one wait cycle per access keeps readdata registered
  assign waitrequest = (read | write) & ~ack;
  assign hit_main = (address == `DLGD_ADDR_MAIN_DAMPING);
  assign hit_aux  = (address == `DLGD_ADDR_AUX_GAIN);
  // writes land on the answer edge, while address and data still stand
  assign wr_en    = write & ack & byteenable[0];

  always_ff @(posedge ref_clk) begin
    if (rst) ack <= 1'b0;
    else ack <= (read | write) & ~ack;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) main_dpll_damping <= `DLGD_RST_MAIN_DAMPING;
    else if (wr_en && hit_main)
      main_dpll_damping <= writedata[7:0] & `DLGD_MASK_MAIN_DAMPING;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) second_dpll_detector_gain <= `DLGD_RST_AUX_GAIN;
    else if (wr_en && hit_aux)
      second_dpll_detector_gain <= writedata[7:0] & `DLGD_MASK_AUX_GAIN;
  end

  // ----------------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------------
  // reserved bits are cleared at write time, so they always read zero
  assign main_damping_select       =
    main_dpll_damping[`DLGD_DAMP_HI:`DLGD_DAMP_LO];
  assign main_lowrate_gain_field   =
    main_dpll_damping[`DLGD_AGAIN_HI:`DLGD_AGAIN_LO];
  assign aux_auto_gain_enable      =
    second_dpll_detector_gain[`DLGD_AUTO_BIT];
  assign aux_analog_feedback_gain  =
    second_dpll_detector_gain[`DLGD_AGAIN_HI:`DLGD_AGAIN_LO];
  assign aux_digital_feedback_gain =
    second_dpll_detector_gain[`DLGD_DGAIN_HI:`DLGD_DGAIN_LO];

  // ----------------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------------
  // unmapped reads return a marker word so a bad address shows at once
  always_comb begin
    next_readdata = `DLGD_UNMAPPED_DATA;
    if (hit_main) begin
      next_readdata = {24'h00_0000, main_dpll_damping};
    end else if (hit_aux) begin
      next_readdata = {24'h00_0000, second_dpll_detector_gain};
    end
  end

  // taken on the request edge, so it stands when waitrequest drops
  always_ff @(posedge ref_clk) begin
    if (rst) readdata <= 32'h0000_0000;
    else if (read && !ack) readdata <= next_readdata;
  end

  // ----------------------------------------------------------------------
  // main loop selections
  // ----------------------------------------------------------------------
  dlgd_damping_lut u_lut (
    .ref_clk (ref_clk),
    .rst     (rst),
    .code    (main_damping_select),
    .bw      (main_bandwidth),
    .factor  (main_damping_factor)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      main_lowrate_analog_gain <= 3'h0;
      main_gain_valid          <= 1'b0;
    end else begin
      main_lowrate_analog_gain <= main_lowrate_gain_field;
      main_gain_valid <= main_analog_lowrate;
    end
  end

  // ----------------------------------------------------------------------
  // aux loop gain choice
  // ----------------------------------------------------------------------
  // digital mode wins if both modes are flagged
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aux_detector_gain <= 3'h0;
      aux_gain_valid    <= 1'b0;
    end else if (aux_digital_mode) begin
      aux_detector_gain <= aux_digital_feedback_gain;
      aux_gain_valid <= 1'b1;
    end else if (aux_analog_mode && aux_auto_gain_enable) begin
      aux_detector_gain <= aux_analog_feedback_gain;
      aux_gain_valid <= 1'b1;
    end else begin
      aux_detector_gain <= 3'h0;
      aux_gain_valid    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // bus checks
  // ----------------------------------------------------------------------
  bus_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("read answer timing wrong");
  bus_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(write) |-> waitrequest ##1 !waitrequest)
    else $error("write answer timing wrong");
  read_back_a: assert property (@(posedge ref_clk) disable iff (rst)
    (read && !ack && hit_aux) |=>
      readdata == {24'h00_0000, $past(second_dpll_detector_gain)})
    else $error("aux gain read-back wrong");

  // ----------------------------------------------------------------------
  // register checks
  // ----------------------------------------------------------------------
  main_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && hit_main) |=> main_dpll_damping ==
      ($past(writedata[7:0]) & `DLGD_MASK_MAIN_DAMPING))
    else $error("damping write lost");
  lane_guard_a: assert property (@(posedge ref_clk) disable iff (rst)
    (write && !byteenable[0]) |=> $stable(main_dpll_damping) &&
      $stable(second_dpll_detector_gain))
    else $error("write without lane 0 landed");
  reserved_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
    (main_dpll_damping & ~`DLGD_MASK_MAIN_DAMPING) == 8'h00 &&
    (second_dpll_detector_gain & ~`DLGD_MASK_AUX_GAIN) == 8'h00)
    else $error("reserved bit set");
  reset_main_a: assert property (@(posedge ref_clk)
    $fell(rst) |-> main_dpll_damping == `DLGD_RST_MAIN_DAMPING)
    else $error("damping reset value wrong");
  reset_aux_a: assert property (@(posedge ref_clk)
    $fell(rst) |-> second_dpll_detector_gain == `DLGD_RST_AUX_GAIN)
    else $error("aux gain reset value wrong");
  aux_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_en && hit_aux) |=> second_dpll_detector_gain ==
      ($past(writedata[7:0]) & `DLGD_MASK_AUX_GAIN))
    else $error("aux gain write lost");

  // ----------------------------------------------------------------------
  // loop output checks
  // ----------------------------------------------------------------------
  damp_code_a: assert property (@(posedge ref_clk) disable iff (rst)
    (main_bandwidth == DLGD_BW_70HZ &&
     main_damping_select == 3'h5) |=> main_damping_factor == 8'hC8)
    else $error("damping lookup wrong");
  damp_slow_a: assert property (@(posedge ref_clk) disable iff (rst)
    (main_bandwidth == DLGD_BW_4HZ && main_damping_select != 3'h0 &&
     main_damping_select <= 3'h5) |=> main_damping_factor == 8'h32)
    else $error("slow column damping wrong");
  damp_unused_a: assert property (@(posedge ref_clk) disable iff (rst)
    (main_damping_select == 3'h0 || main_damping_select > 3'h5)
    |=> main_damping_factor == 8'h00)
    else $error("unused damping code not zero");
  main_gain_a: assert property (@(posedge ref_clk) disable iff (rst)
    main_analog_lowrate |=> main_gain_valid &&
      main_lowrate_analog_gain == $past(main_lowrate_gain_field))
    else $error("main lowrate gain wrong");
  main_gain_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !main_analog_lowrate |=> !main_gain_valid)
    else $error("main lowrate gain valid too long");
  aux_analog_a: assert property (@(posedge ref_clk) disable iff (rst)
    (aux_analog_mode && !aux_digital_mode && aux_auto_gain_enable)
    |=> aux_gain_valid && aux_detector_gain == $past(aux_analog_feedback_gain))
    else $error("aux analog gain wrong");
  aux_digital_a: assert property (@(posedge ref_clk) disable iff (rst)
    aux_digital_mode |=> aux_gain_valid &&
      aux_detector_gain == $past(aux_digital_feedback_gain))
    else $error("aux digital gain wrong");
  aux_disable_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!aux_auto_gain_enable && !aux_digital_mode) |=> !aux_gain_valid)
    else $error("auto gain not disabled");
  aux_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!aux_analog_mode && !aux_digital_mode) |=>
      !aux_gain_valid && aux_detector_gain == 3'h0)
    else $error("aux gain given with no mode");
endmodule

// File: logic/dlgd_defines.svh
// Purpose: offsets, fields, reset values for the loop gain/damping registers
// Assumes: avalon word addressing by byte address / 4
// Notes:   definitions only
`ifndef DLGD_DEFINES_SVH
`define DLGD_DEFINES_SVH

// ----------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------
`define DLGD_IDX_MAIN_DAMPING  8'h6B
`define DLGD_IDX_AUX_GAIN      8'h6C
`define DLGD_ADDR_W            10
`define DLGD_ADDR_MAIN_DAMPING 10'h1AC
`define DLGD_ADDR_AUX_GAIN     10'h1B0

// ----------------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------------
`define DLGD_RST_MAIN_DAMPING  8'h13
`define DLGD_RST_AUX_GAIN      8'hC2
`define DLGD_MASK_MAIN_DAMPING 8'h77
`define DLGD_MASK_AUX_GAIN     8'hF7
`define DLGD_DAMP_LO           0
`define DLGD_DAMP_HI           2
`define DLGD_AGAIN_LO          4
`define DLGD_AGAIN_HI          6
`define DLGD_DGAIN_LO          0
`define DLGD_DGAIN_HI          2
`define DLGD_AUTO_BIT          7
`define DLGD_UNMAPPED_DATA     32'hDEAD_0000

`endif

// File: logic/dlgd_pkg.sv
// Purpose: shared types for the loop gain/damping registers
// Assumes: nothing
// Notes:   damping factors are carried in tenths
package dlgd_pkg;
  typedef logic [2:0] dlgd_gain_t;
  typedef logic [7:0] dlgd_damp_t;
  typedef enum logic [3:0] {
    DLGD_BW_4HZ  = 4'h1,
    DLGD_BW_8HZ  = 4'h2,
    DLGD_BW_35HZ = 4'h4,
    DLGD_BW_70HZ = 4'h8
  } dlgd_bw_e;
endpackage

// File: logic/dlgd_damping_lut.sv
// Purpose: damping factor lookup by code and bandwidth column
// Assumes: bandwidth one-hot; factor in tenths, registered
// Notes:   unused codes give zero
`include "dlgd_defines.svh"
module dlgd_damping_lut
  import dlgd_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // lookup
  input  wire logic [2:0] code,
  input  wire dlgd_bw_e   bw,
  output dlgd_damp_t      factor
);
  dlgd_damp_t next_factor;

  // ----------------------------------------------------------------------
  // table: rows codes 1..5, columns 4/8/35/70 Hz
  // ----------------------------------------------------------------------
  always_comb begin
    next_factor = 8'h00;
    unique case (bw)
      DLGD_BW_4HZ: begin
        if (code >= 3'h1 && code <= 3'h5) next_factor = 8'h32;
      end
      DLGD_BW_8HZ: begin
        if (code == 3'h1) next_factor = 8'h19;
        else if (code >= 3'h2 && code <= 3'h5) next_factor = 8'h32;
      end
      DLGD_BW_35HZ: begin
        unique case (code)
          3'h1:    next_factor = 8'h0C;
          3'h2:    next_factor = 8'h19;
          3'h3:    next_factor = 8'h32;
          3'h4:    next_factor = 8'h64;
          3'h5:    next_factor = 8'h64;
          default: next_factor = 8'h00;
        endcase
      end
      DLGD_BW_70HZ: begin
        unique case (code)
          3'h1:    next_factor = 8'h0C;
          3'h2:    next_factor = 8'h19;
          3'h3:    next_factor = 8'h32;
          3'h4:    next_factor = 8'h64;
          3'h5:    next_factor = 8'hC8;
          default: next_factor = 8'h00;
        endcase
      end
      default: next_factor = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) factor <= 8'h00;
    else factor <= next_factor;
  end
endmodule

// File: verif/dlgd_regs_tb_top.sv
// Purpose: self-checking bench for the loop gain/damping registers
// Assumes: one wait cycle per access, loop outputs settle in 3 cycles
// Notes:   random data from a fixed seed, corner values mixed in
`include "dlgd_defines.svh"
module dpll_loop_gain_damping_cfg_tb_top
  import dlgd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        ref_clk    = 1'b0;
  logic        rst        = 1'b1;
  logic        read       = 1'b0;
  logic        write      = 1'b0;
  logic        an         = 1'b0;
  logic        am         = 1'b0;
  logic        dm         = 1'b0;
  logic [9:0]  address    = 10'h000;
  logic [31:0] writedata  = 32'h0;
  logic [3:0]  byteenable = 4'h0;
  dlgd_bw_e    bw         = DLGD_BW_4HZ;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        mgv;
  logic        agv;
  dlgd_damp_t  mdf;
  dlgd_gain_t  mlg;
  dlgd_gain_t  adg;
  int          err_total   = 0;
  int          checks_done = 0;
  int          seed        = 13;

  always #5 ref_clk = ~ref_clk;

  dlgd_regs dlgd_regs_i (
    .ref_clk(ref_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .main_bandwidth(bw), .main_analog_lowrate(an),
    .main_damping_factor(mdf), .main_lowrate_analog_gain(mlg),
    .main_gain_valid(mgv), .aux_analog_mode(am),
    .aux_digital_mode(dm), .aux_detector_gain(adg),
    .aux_gain_valid(agv));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // starts on an edge of its own so strobes never toggle twice at once
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [7:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    address    <= a;
    writedata  <= {24'h0, d};
    byteenable <= be;
    read       <= !w;
    write      <= w;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      err_total++;
      final_report();
    end
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge ref_clk);
  endtask

  // damping in tenths, columns 4, 8, 35, 70 Hz
  function automatic logic [7:0] damp_exp(input int c, input int b);
    logic [7:0] t [1:5][0:3];
    t[1] = '{8'h32, 8'h19, 8'h0C, 8'h0C};
    t[2] = '{8'h32, 8'h32, 8'h19, 8'h19};
    t[3] = '{8'h32, 8'h32, 8'h32, 8'h32};
    t[4] = '{8'h32, 8'h32, 8'h64, 8'h64};
    t[5] = '{8'h32, 8'h32, 8'h64, 8'hC8};
    return (c >= 1 && c <= 5) ? t[c][b] : 8'h00;
  endfunction

  function automatic logic [3:0] aux_exp(input logic [7:0] r,
                                         input logic a, input logic d);
    if (d) return {1'b1, r[2:0]};
    if (a && r[7]) return {1'b1, r[6:4]};
    return 4'h0;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic [7:0]  v;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, `DLGD_ADDR_MAIN_DAMPING, 8'h00, 4'hF, q);
    chk(q, 32'h13);
    bus(1'b0, `DLGD_ADDR_AUX_GAIN, 8'h00, 4'hF, q);
    chk(q, 32'hC2);
    settle();
    chk({24'h0, mdf}, 32'h32);
    $display("reset values done");
    for (int c = 0; c < 8; c++) begin
      for (int b = 0; b < 4; b++) begin
        v = $random(seed);
        v[2:0] = c[2:0];
        bw <= dlgd_bw_e'(4'h1 << b);
        an <= v[7];
        bus(1'b1, `DLGD_ADDR_MAIN_DAMPING, v, 4'h1, q);
        bus(1'b0, `DLGD_ADDR_MAIN_DAMPING, 8'h00, 4'hF, q);
        chk(q, {24'h0, v & 8'h77});
        settle();
        chk({24'h0, mdf}, {24'h0, damp_exp(c, b)});
        chk({28'h0, mgv, mlg}, {28'h0, v[7], v[6:4]});
      end
    end
    $display("damping table done");
    for (int i = 0; i < 24; i++) begin
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h70 : 8'h00;
      if (i > 2) v = $random(seed);
      am <= (i < 3) ? 1'b1 : $random(seed);
      dm <= (i < 3) ? 1'b0 : $random(seed);
      bus(1'b1, `DLGD_ADDR_AUX_GAIN, v, 4'h1, q);
      bus(1'b0, `DLGD_ADDR_AUX_GAIN, 8'h00, 4'hF, q);
      chk(q, {24'h0, v & 8'hF7});
      settle();
      chk({28'h0, agv, adg}, {28'h0, aux_exp(v, am, dm)});
    end
    $display("aux gain done");
    bus(1'b1, `DLGD_ADDR_AUX_GAIN, ~v, 4'hE, q);
    bus(1'b0, `DLGD_ADDR_AUX_GAIN, 8'h00, 4'hF, q);
    chk(q, {24'h0, v & 8'hF7});
    bus(1'b0, 10'h000, 8'h00, 4'hF, q);
    chk(q, `DLGD_UNMAPPED_DATA);
    $display("refused accesses done");
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, `DLGD_ADDR_MAIN_DAMPING, 8'h00, 4'hF, q);
    chk(q, 32'h13);
    bus(1'b0, `DLGD_ADDR_AUX_GAIN, 8'h00, 4'hF, q);
    chk(q, 32'hC2);
    $display("mid-run reset done");
    final_report();
  end
endmodule
